// >>> core/mbp_port.sv
// muxed byte port: gpio, external data bus or host data bus on eight pins
// What this block does
// - direction register is write-only; reading its address returns all ones.
// - expanded modes ignore direction; all eight pins form the external data bus.
// - external data bus pins float during reset, hardware and software standby.
// - single-chip gpio: direction 1 drives stored output, direction 0 is input.
// - reset and hardware standby clear direction; software standby keeps it.
// - port read gives output register where direction is 1, pin level elsewhere.
// - output data register is read/write, cleared by reset and hardware standby.
// - pull-up is on only when direction bit is 0 and pull-up bit is 1.
// - pull-up register is read/write, cleared by reset and hardware standby.
// - with host interface enabled all pull-ups stay off.
// - pull-ups off in expanded modes always, and in reset or hardware standby.
// - single-chip, host enable 0: port is gpio under the direction register.
// - single-chip, host enable 1: all eight pins carry the host data bus.
// - software standby in single-chip mode keeps each pull-up state unchanged.
//
// The implementer's own choice: the plain strobed port.
module mbp_port
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  op_mode,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  ext_bus_out,
  input  wire logic        ext_bus_drive,
  output logic      [7:0]  ext_bus_in,
  input  wire logic [7:0]  host_if_data_out,
  input  wire logic        host_if_data_drive,
  output logic      [7:0]  host_if_data_in,
  output logic             host_if_enable,
  input  wire logic [7:0]  port_pins_i,
  output logic      [7:0]  port_pins_o,
  output logic      [7:0]  port_pins_oe,
  output logic      [7:0]  pin_pullup_on
);

  logic [7:0] pin_direction_q;
  logic [7:0] pin_output_data_q;
  logic [7:0] pin_pullup_enable_q;
  logic [7:0] sys_ctrl_q;
  logic [7:0] pins_meta_q;
  logic [7:0] pins_sync_q;
  logic [7:0] rdata_q;
  logic [7:0] pins_o_q;
  logic [7:0] pins_oe_q;
  logic [7:0] pullup_q;
  logic [7:0] rdata_d;
  logic [7:0] pins_o_d;
  logic [7:0] pins_oe_d;
  logic [7:0] pullup_d;
  logic       expanded;
  logic       clear_regs;
  mbp_pkg::mbp_owner_e owner;

  // hardware standby acts like reset on the port registers
  assign clear_regs = hw_standby;
  assign expanded   = (op_mode != mbp_pkg::MODE_SINGLE);
  assign host_if_enable = sys_ctrl_q[mbp_pkg::HIE_BIT];

  // pin owner from mode and host enable
  // expanded modes win over a stale host enable bit: the host bus exists
  // only in single-chip mode, so the bit is ignored elsewhere
  always_comb
  begin
    if (expanded)
      owner = mbp_pkg::MBP_OWN_EXT;
    else if (host_if_enable)
      owner = mbp_pkg::MBP_OWN_HOST;
    else
      owner = mbp_pkg::MBP_OWN_GPIO;
  end

  // two-flop synchroniser on the pin levels; only stage two is read
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pins_meta_q <= 8'h00;
      pins_sync_q <= 8'h00;
    end
    else
    begin
      pins_meta_q <= port_pins_i;
      pins_sync_q <= pins_meta_q;
    end
  end

  // direction register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pin_direction_q <= mbp_pkg::RST_DIRECTION;
    else if (clear_regs)
      pin_direction_q <= mbp_pkg::RST_DIRECTION;
    else if (reg_wr && reg_addr == mbp_pkg::ADDR_DIRECTION)
      pin_direction_q <= reg_wdata;
  end

  // output data register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pin_output_data_q <= mbp_pkg::RST_OUTPUT;
    else if (clear_regs)
      pin_output_data_q <= mbp_pkg::RST_OUTPUT;
    else if (reg_wr && reg_addr == mbp_pkg::ADDR_OUTPUT)
      pin_output_data_q <= reg_wdata;
  end

  // pull-up control register; software standby simply leaves it alone
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pin_pullup_enable_q <= mbp_pkg::RST_PULLUP;
    else if (clear_regs)
      pin_pullup_enable_q <= mbp_pkg::RST_PULLUP;
    else if (reg_wr && reg_addr == mbp_pkg::ADDR_PULLUP)
      pin_pullup_enable_q <= reg_wdata;
  end

  // system control byte holding the host interface enable bit
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sys_ctrl_q <= mbp_pkg::RST_SYS_CTRL;
    else if (clear_regs)
      sys_ctrl_q <= mbp_pkg::RST_SYS_CTRL;
    else if (reg_wr && reg_addr == mbp_pkg::ADDR_SYS_CTRL)
      sys_ctrl_q <= {7'h00, reg_wdata[mbp_pkg::HIE_BIT]};
  end

  // read mux; port read merges output register and synced pins
  // direction never reads back, so software must keep its own copy of it
  always_comb
  begin
    case (reg_addr)
      mbp_pkg::ADDR_DIRECTION: rdata_d = mbp_pkg::DIR_READ_VALUE;
      mbp_pkg::ADDR_OUTPUT:
        rdata_d = (pin_direction_q & pin_output_data_q)
                | (~pin_direction_q & pins_sync_q);
      mbp_pkg::ADDR_PULLUP:    rdata_d = pin_pullup_enable_q;
      mbp_pkg::ADDR_SYS_CTRL:  rdata_d = sys_ctrl_q;
      default:                 rdata_d = mbp_pkg::UNMAPPED_VALUE;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 8'h00;
  end
  assign reg_rdata = rdata_q;

  // pin drive selection by owner; standby floats the external bus
  always_comb
  begin
    pins_o_d  = 8'h00;
    pins_oe_d = 8'h00;
    case (owner)
      mbp_pkg::MBP_OWN_GPIO:
      begin
        pins_o_d  = pin_output_data_q;
        pins_oe_d = pin_direction_q;
      end
      mbp_pkg::MBP_OWN_EXT:
      begin
        pins_o_d  = ext_bus_out;
        pins_oe_d = (hw_standby || sw_standby) ? 8'h00 : {8{ext_bus_drive}};
      end
      mbp_pkg::MBP_OWN_HOST:
      begin
        pins_o_d  = host_if_data_out;
        pins_oe_d = {8{host_if_data_drive}};
      end
      default:
      begin
        pins_o_d  = 8'h00;
        pins_oe_d = 8'h00;
      end
    endcase
  end

  // pull-up gating; in software standby the registers hold so state holds
  // hw standby also clears the registers, but gating here saves a stale cycle
  always_comb
  begin
    if (expanded || host_if_enable || hw_standby)
      pullup_d = 8'h00;
    else
      pullup_d = pin_pullup_enable_q & ~pin_direction_q;
  end

  // registered pin outputs; reset gives all pins floating, pull-ups off
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pins_o_q  <= 8'h00;
      pins_oe_q <= 8'h00;
      pullup_q  <= 8'h00;
    end
    else
    begin
      pins_o_q  <= pins_o_d;
      pins_oe_q <= pins_oe_d;
      pullup_q  <= pullup_d;
    end
  end
  assign port_pins_o   = pins_o_q;
  assign port_pins_oe  = pins_oe_q;
  assign pin_pullup_on = pullup_q;

  // synced pin levels routed to the bus owners
  assign ext_bus_in      = pins_sync_q;
  assign host_if_data_in = pins_sync_q;

  // checks
  a_dir_reads_ones: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == mbp_pkg::ADDR_DIRECTION |=> reg_rdata == 8'hFF)
    else $error("direction read not all ones");
  a_exp_floats_standby: assert property (@(posedge core_clk) disable iff (rst)
    op_mode != mbp_pkg::MODE_SINGLE && (sw_standby || hw_standby) |=> port_pins_oe == 8'h00)
    else $error("external bus driven in standby");
  a_exp_ignores_dir: assert property (@(posedge core_clk) disable iff (rst)
    op_mode != mbp_pkg::MODE_SINGLE && !sw_standby && !hw_standby
    |=> port_pins_oe == {8{$past(ext_bus_drive)}})
    else $error("expanded mode drive not from bus");
  a_gpio_drive: assert property (@(posedge core_clk) disable iff (rst)
    op_mode == mbp_pkg::MODE_SINGLE && !host_if_enable
    |=> port_pins_oe == $past(pin_direction_q) && port_pins_o == $past(pin_output_data_q))
    else $error("gpio drive mismatch");
  a_hwstby_clears: assert property (@(posedge core_clk) disable iff (rst)
    hw_standby |=> pin_direction_q == 8'h00 && pin_output_data_q == 8'h00
                   && pin_pullup_enable_q == 8'h00)
    else $error("hardware standby did not clear");
  a_swstby_keeps: assert property (@(posedge core_clk) disable iff (rst)
    sw_standby && !hw_standby && !reg_wr |=> $stable(pin_direction_q)
                                             && $stable(pin_pullup_enable_q))
    else $error("software standby lost state");
  a_port_read_mix: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == mbp_pkg::ADDR_OUTPUT |=> reg_rdata ==
      (($past(pin_direction_q) & $past(pin_output_data_q))
      | (~$past(pin_direction_q) & $past(pins_sync_q))))
    else $error("port read mismatch");
  a_pullup_gate: assert property (@(posedge core_clk) disable iff (rst)
    ##1 (pin_pullup_on & $past(pin_direction_q)) == 8'h00
        && (pin_pullup_on & ~$past(pin_pullup_enable_q)) == 8'h00)
    else $error("pull-up on for output or disabled pin");
  a_pullup_host_off: assert property (@(posedge core_clk) disable iff (rst)
    host_if_enable || op_mode != mbp_pkg::MODE_SINGLE |=> pin_pullup_on == 8'h00)
    else $error("pull-up on in host or expanded mode");
  a_write_takes: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == mbp_pkg::ADDR_OUTPUT && !hw_standby
    |=> pin_output_data_q == $past(reg_wdata))
    else $error("output register write lost");

  // register bus: writes land, reads stand one cycle
  a_dir_write_takes: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == mbp_pkg::ADDR_DIRECTION && !hw_standby
    |=> pin_direction_q == $past(reg_wdata))
    else $error("direction register write lost");
  a_pullup_write_takes: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == mbp_pkg::ADDR_PULLUP && !hw_standby
    |=> pin_pullup_enable_q == $past(reg_wdata))
    else $error("pull-up register write lost");
  a_pullup_reads_back: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == mbp_pkg::ADDR_PULLUP
    |=> reg_rdata == $past(pin_pullup_enable_q))
    else $error("pull-up register read mismatch");
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  // standby and expanded mode: software standby keeps, hardware standby and expanded mode keep pull-ups off
  a_out_sw_keeps: assert property (@(posedge core_clk) disable iff (rst)
    sw_standby && !hw_standby && !reg_wr |=> $stable(pin_output_data_q))
    else $error("software standby lost output data");
  a_dir_sw_keeps: assert property (@(posedge core_clk) disable iff (rst)
    sw_standby && !hw_standby && !reg_wr |=> $stable(pin_direction_q))
    else $error("software standby lost direction");
  a_hw_pullup_off: assert property (@(posedge core_clk) disable iff (rst)
    hw_standby |=> pin_pullup_on == 8'h00)
    else $error("pull-up on in hardware standby");
  a_exp_pullup_off: assert property (@(posedge core_clk) disable iff (rst)
    op_mode != mbp_pkg::MODE_SINGLE |=> pin_pullup_on == 8'h00)
    else $error("pull-up on in expanded mode");

  // pin ownership and drive
  a_exp_owner: assert property (@(posedge core_clk) disable iff (rst)
    op_mode != mbp_pkg::MODE_SINGLE |-> owner == mbp_pkg::MBP_OWN_EXT)
    else $error("expanded mode not on external bus");
  a_gpio_owner: assert property (@(posedge core_clk) disable iff (rst)
    op_mode == mbp_pkg::MODE_SINGLE && !host_if_enable |-> owner == mbp_pkg::MBP_OWN_GPIO)
    else $error("single-chip port not general purpose");
  a_host_owner: assert property (@(posedge core_clk) disable iff (rst)
    op_mode == mbp_pkg::MODE_SINGLE && host_if_enable |-> owner == mbp_pkg::MBP_OWN_HOST)
    else $error("host enable did not take the pins");
  a_host_drive: assert property (@(posedge core_clk) disable iff (rst)
    op_mode == mbp_pkg::MODE_SINGLE && host_if_enable
    |=> port_pins_oe == {8{$past(host_if_data_drive)}}
        && port_pins_o == $past(host_if_data_out))
    else $error("host data bus drive mismatch");
  a_gpio_pullup_value: assert property (@(posedge core_clk) disable iff (rst)
    op_mode == mbp_pkg::MODE_SINGLE && !host_if_enable && !hw_standby
    |=> pin_pullup_on == ($past(pin_pullup_enable_q) & ~$past(pin_direction_q)))
    else $error("gpio pull-up state mismatch");

  // pin levels reach the bus owners two clocks late
  a_pin_sync_delay: assert property (@(posedge core_clk) disable iff (rst)
    ##2 ext_bus_in == $past(port_pins_i, 2))
    else $error("external bus input not two clocks late");
  a_host_in_sync: assert property (@(posedge core_clk) disable iff (rst)
    ##2 host_if_data_in == $past(port_pins_i, 2))
    else $error("host bus input not two clocks late");

  c_gpio_out: cover property (@(posedge core_clk) disable iff (rst)
    owner == mbp_pkg::MBP_OWN_GPIO && port_pins_oe != 8'h00);
  c_host_mode: cover property (@(posedge core_clk) disable iff (rst)
    owner == mbp_pkg::MBP_OWN_HOST);
  c_exp_drive: cover property (@(posedge core_clk) disable iff (rst)
    owner == mbp_pkg::MBP_OWN_EXT && port_pins_oe == 8'hFF);
  c_pullup_on: cover property (@(posedge core_clk) disable iff (rst) pin_pullup_on != 8'h00);
  c_sw_standby: cover property (@(posedge core_clk) disable iff (rst)
    sw_standby && pin_pullup_on != 8'h00);

endmodule

// >>> core/mbp_pkg.sv
// package: register offsets, reset values and mode codes for the muxed byte port
package mbp_pkg;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] ADDR_PULLUP     = 16'hFFAE;
  localparam logic [15:0] ADDR_DIRECTION  = 16'hFFB4;
  localparam logic [15:0] ADDR_OUTPUT     = 16'hFFB6;
  localparam logic [15:0] ADDR_SYS_CTRL   = 16'hFFC0;
  localparam logic [7:0]  RST_PULLUP      = 8'h00;
  localparam logic [7:0]  RST_DIRECTION   = 8'h00;
  localparam logic [7:0]  RST_OUTPUT      = 8'h00;
  localparam logic [7:0]  RST_SYS_CTRL    = 8'h00;
  localparam logic [7:0]  DIR_READ_VALUE  = 8'hFF;
  localparam logic [7:0]  UNMAPPED_VALUE  = 8'h00;
  localparam int          HIE_BIT         = 0;
  // operating mode codes on the mode input
  localparam logic [1:0]  MODE_EXP_ROMOFF = 2'h1;
  localparam logic [1:0]  MODE_EXP_ROMON  = 2'h2;
  localparam logic [1:0]  MODE_SINGLE     = 2'h3;
  // pin-owner selection
  typedef enum logic [2:0] {
    MBP_OWN_GPIO = 3'b001,
    MBP_OWN_EXT  = 3'b010,
    MBP_OWN_HOST = 3'b100
  } mbp_owner_e;
endpackage

// >>> tb/mbp_pin_model.sv
// pin model: resolves the eight port pins from every party that may drive them
module mbp_pin_model
(
  input  wire logic       core_clk,
  input  wire logic [7:0] pins_o,
  input  wire logic [7:0] pins_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] drv_val,
  input  wire logic [7:0] drv_en,
  output logic      [7:0] pins_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  // device wins a clash; a floating pin flips every cycle so a stale level never matches
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pins_oe[i]) pins_i[i] = pins_o[i];
      else if (drv_en[i]) pins_i[i] = drv_val[i];
      else if (pullup_on[i]) pins_i[i] = 1'b1;
      else pins_i[i] = ~last_q[i];
    end
  end
  // remember the level so an undriven pin can invert it
  always @(posedge core_clk) last_q <= pins_i;
endmodule

// >>> tb/testbench.sv
// testbench: register access, pin resolution and mode switching of the muxed byte port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] A_OUT = mbp_pkg::ADDR_OUTPUT;
  localparam logic [15:0] A_DIR = mbp_pkg::ADDR_DIRECTION;
  localparam logic [15:0] A_PU  = mbp_pkg::ADDR_PULLUP;
  logic        core_clk, rst, hw_standby, sw_standby, reg_wr, reg_rd;
  logic        ext_bus_drive, host_if_data_drive, host_if_enable;
  logic [1:0]  op_mode;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, ext_bus_out, ext_bus_in, host_if_data_out;
  logic [7:0]  host_if_data_in, port_pins_i, port_pins_o, port_pins_oe, pin_pullup_on;
  logic [7:0]  drv_val, drv_en;
  logic [1:0]  modes [2] = '{mbp_pkg::MODE_EXP_ROMOFF, mbp_pkg::MODE_EXP_ROMON};
  int          error_cnt, compares;
  mbp_port dut_u (.core_clk(core_clk), .rst(rst), .op_mode(op_mode), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_bus_out(ext_bus_out),
    .ext_bus_drive(ext_bus_drive), .ext_bus_in(ext_bus_in), .host_if_data_out(host_if_data_out),
    .host_if_data_drive(host_if_data_drive), .host_if_data_in(host_if_data_in),
    .host_if_enable(host_if_enable), .port_pins_i(port_pins_i), .port_pins_o(port_pins_o),
    .port_pins_oe(port_pins_oe), .pin_pullup_on(pin_pullup_on));
  mbp_pin_model pins_u (.core_clk(core_clk), .pins_o(port_pins_o), .pins_oe(port_pins_oe),
    .pullup_on(pin_pullup_on), .drv_val(drv_val), .drv_en(drv_en), .pins_i(port_pins_i));
  always #4 core_clk = ~core_clk;
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one-cycle write strobe; the register holds the byte from the edge that takes it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input string name, input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(name, exp, reg_rdata);
  endtask
  // hang guard: a run that never reaches its end counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end
  initial
  begin
    {core_clk, hw_standby, sw_standby, reg_wr, reg_rd, ext_bus_drive} = '0;
    {reg_addr, reg_wdata, ext_bus_out, host_if_data_out, drv_val} = '0;
    {host_if_data_drive, error_cnt, compares} = '0;
    rst = 1'b1;
    op_mode = mbp_pkg::MODE_SINGLE;
    drv_en = 8'hFF;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    settle(3);
    rd("port", A_OUT, 8'h00);
    rd("pullup reg", A_PU, 8'h00);
    rd("dir reg", A_DIR, 8'hFF);
    rd("unmapped", 16'hFF00, mbp_pkg::UNMAPPED_VALUE);
    // general purpose: upper nibble driven, lower nibble read from the pins
    drv_val <= 8'h03;
    drv_en <= 8'h0F;
    wr(A_DIR, 8'hF0);
    wr(A_OUT, 8'hA5);
    settle(1);
    chk("oe", 8'hF0, port_pins_oe);
    chk("pin out", 8'hA0, port_pins_o & 8'hF0);
    settle(2);
    rd("port", A_OUT, 8'hA3);
    rd("dir reg", A_DIR, 8'hFF);
    wr(A_PU, 8'hFF);
    settle(1);
    chk("pullup", 8'h0F, pin_pullup_on);
    rd("pullup reg", A_PU, 8'hFF);
    drv_en <= 8'h00;
    settle(3);
    rd("port", A_OUT, 8'hAF);
    // software standby keeps everything; hardware standby clears it
    @(posedge core_clk);
    sw_standby <= 1'b1;
    settle(2);
    chk("pullup", 8'h0F, pin_pullup_on);
    chk("oe", 8'hF0, port_pins_oe);
    @(posedge core_clk);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    settle(2);
    chk("pullup", 8'h00, pin_pullup_on);
    chk("oe", 8'h00, port_pins_oe);
    @(posedge core_clk);
    hw_standby <= 1'b0;
    drv_val <= 8'h5C;
    drv_en <= 8'hFF;
    settle(3);
    rd("pullup reg", A_PU, 8'h00);
    rd("port", A_OUT, 8'h5C);
    wr(A_DIR, 8'hFF);
    rd("port", A_OUT, 8'h00);
    // host interface takes the pins and blocks the pull-ups
    wr(A_DIR, 8'h00);
    wr(A_PU, 8'hFF);
    settle(1);
    chk("pullup", 8'hFF, pin_pullup_on);
    wr(mbp_pkg::ADDR_SYS_CTRL, 8'h01 << mbp_pkg::HIE_BIT);
    host_if_data_out <= 8'h96;
    host_if_data_drive <= 1'b1;
    drv_en <= 8'h00;
    settle(2);
    chk("host en", 8'h01, {7'h00, host_if_enable});
    chk("pullup", 8'h00, pin_pullup_on);
    chk("oe", 8'hFF, port_pins_oe);
    chk("pin out", 8'h96, port_pins_o);
    @(posedge core_clk);
    host_if_data_drive <= 1'b0;
    drv_val <= 8'h3C;
    drv_en <= 8'hFF;
    settle(3);
    chk("host in", 8'h3C, host_if_data_in);
    wr(mbp_pkg::ADDR_SYS_CTRL, 8'h00);
    wr(A_DIR, 8'h0F);
    // expanded modes: direction ignored, bus floats in software standby
    foreach (modes[i])
    begin
      @(posedge core_clk);
      ext_bus_drive <= 1'b0;
      op_mode <= modes[i];
      ext_bus_out <= 8'hC5;
      drv_val <= 8'h69;
      drv_en <= 8'hFF;
      settle(3);
      chk("oe", 8'h00, port_pins_oe);
      chk("pullup", 8'h00, pin_pullup_on);
      chk("bus in", 8'h69, ext_bus_in);
      @(posedge core_clk);
      ext_bus_drive <= 1'b1;
      drv_en <= 8'h00;
      settle(2);
      chk("oe", 8'hFF, port_pins_oe);
      chk("pin out", 8'hC5, port_pins_o);
      @(posedge core_clk);
      sw_standby <= 1'b1;
      settle(2);
      chk("oe", 8'h00, port_pins_oe);
      @(posedge core_clk);
      sw_standby <= 1'b0;
      settle(2);
    end
    @(posedge core_clk);
    rst <= 1'b1;
    settle(1);
    chk("oe", 8'h00, port_pins_oe);
    complete_run();
  end
endmodule
